/* dprc_pkg.sv */
// shared constants, types and helpers of the dual-port ram clocking block
package dprc_pkg;

	// capacity of one embedded_memory_block in bits
	localparam int DPRC_BLOCK_BITS = 4096;

	// block organisations, deepest-narrowest last
	typedef enum logic [1:0] {
		DPRC_SHAPE_256X16,
		DPRC_SHAPE_512X8,
		DPRC_SHAPE_1024X4,
		DPRC_SHAPE_2048X2
	} dprc_shape_t;

	localparam int DPRC_AW_256 = 8;
	localparam int DPRC_AW_512 = 9;
	localparam int DPRC_AW_1024 = 10;
	localparam int DPRC_AW_2048 = 11;
	localparam int DPRC_W_256 = 16;
	localparam int DPRC_W_512 = 8;
	localparam int DPRC_W_1024 = 4;
	localparam int DPRC_W_2048 = 2;

	// clocking schemes of the register groups
	typedef enum logic [1:0] {
		DPRC_MODE_SEP_RW,
		DPRC_MODE_SEP_IO,
		DPRC_MODE_SINGLE
	} dprc_clk_mode_t;

	// bit positions in the registering select word
	localparam int DPRC_SEL_DIN = 0;
	localparam int DPRC_SEL_WADDR = 1;
	localparam int DPRC_SEL_WE = 2;
	localparam int DPRC_SEL_RADDR = 3;
	localparam int DPRC_SEL_RE = 4;
	localparam int DPRC_SEL_DOUT = 5;
	localparam int DPRC_SEL_W = 6;

	// widest shape that still holds the requested depth
	function automatic dprc_shape_t dprc_shape_of(input int aw);
		if (aw <= DPRC_AW_256) begin
			return DPRC_SHAPE_256X16;
		end else if (aw == DPRC_AW_512) begin
			return DPRC_SHAPE_512X8;
		end else if (aw == DPRC_AW_1024) begin
			return DPRC_SHAPE_1024X4;
		end
		return DPRC_SHAPE_2048X2;
	endfunction

	function automatic int dprc_shape_width(input dprc_shape_t s);
		case (s)
			DPRC_SHAPE_256X16: return DPRC_W_256;
			DPRC_SHAPE_512X8: return DPRC_W_512;
			DPRC_SHAPE_1024X4: return DPRC_W_1024;
			default: return DPRC_W_2048;
		endcase
	endfunction

	function automatic int dprc_shape_aw(input dprc_shape_t s);
		case (s)
			DPRC_SHAPE_256X16: return DPRC_AW_256;
			DPRC_SHAPE_512X8: return DPRC_AW_512;
			DPRC_SHAPE_1024X4: return DPRC_AW_1024;
			default: return DPRC_AW_2048;
		endcase
	endfunction

	// blocks placed side by side to reach the requested word width
	function automatic int dprc_blocks(input int dw, input int aw);
		int bw;
		bw = dprc_shape_width(dprc_shape_of(aw));
		return (dw + bw - 1) / bw;
	endfunction

endpackage

/* dprc_mem_if.sv */
// port bundle between the clocking logic and one memory block
`timescale 1ns/1ns
interface dprc_mem_if #(
	parameter int AW = 8,
	parameter int BW = 16
);
	logic we;
	logic [AW-1:0] waddr;
	logic [BW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [BW-1:0] rdata;

	modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* dprc_mem_block.sv */
// one 4096-bit embedded_memory_block with separate write and read ports
`timescale 1ns/1ns
module dprc_mem_block
	import dprc_pkg::*;
#(
	parameter dprc_shape_t SHAPE = DPRC_SHAPE_256X16,
	parameter logic [DPRC_BLOCK_BITS-1:0] INIT_IMAGE = '0
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// ports
	dprc_mem_if.mem port
);
	localparam int BW = dprc_shape_width(SHAPE);
	localparam int AW = dprc_shape_aw(SHAPE);
	localparam int DEPTH = DPRC_BLOCK_BITS / BW;

	logic [BW-1:0] mem_q [DEPTH];
	logic [BW-1:0] mem_d [DEPTH];

	always_comb begin
		mem_d = mem_q;
		if (port.we) begin
			mem_d[port.waddr] = port.wdata;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= INIT_IMAGE[i*BW +: BW];
			end
		end else begin
			mem_q <= mem_d;
		end
	end

	assign port.rdata = mem_q[port.raddr];

	a_write_lands: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		port.we |=> mem_q[$past(port.waddr)] == $past(port.wdata))
		else $error("written word not found in memory");

endmodule // dprc_mem_block

/* dprc_ram.sv */
// dual-port ram with selectable registering and three clocking schemes
//
// Overview of operation
// - block shape is 256x16, 512x8, 1024x4 or 2048x2 by address width.
// - every memory block holds exactly 4096 bits whatever its shape.
// - write data and read data travel on separate buses.
// - write and read addresses are separate inputs and may differ.
// - each input may be captured in a register or applied directly.
// - input and output register groups each have their own clock enable.
// - a write and a read may happen in the same cycle.
// - data width and address width are build-time parameters.
// - wider words use several blocks side by side.
// - memory starts from a preset image instead of undefined contents.
// - write address and enable use input clock; data out uses output clock.
// - read address and enable go to input or output clock by mode.
// - separate read/write mode puts read address, enable, data out on output clock.
// - separate input/output mode puts only data out on output clock.
// - the two clock ticks need no rate or phase relation.
`timescale 1ns/1ns
module dprc_ram
	import dprc_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int ADDR_W = 8,
	parameter logic [dprc_blocks(DATA_W, ADDR_W)*DPRC_BLOCK_BITS-1:0] INIT_IMAGE = '0
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic aclr_i,
	// clock ticks and clock enables
	input wire logic in_tick_i,
	input wire logic out_tick_i,
	input wire logic in_clken_i,
	input wire logic out_clken_i,
	// configuration
	input wire logic [1:0] clk_mode_i,
	input wire logic [DPRC_SEL_W-1:0] reg_sel_i,
	// write side
	input wire logic [DATA_W-1:0] wr_data_i,
	input wire logic [ADDR_W-1:0] wr_addr_i,
	input wire logic wr_en_i,
	// read side
	input wire logic [ADDR_W-1:0] rd_addr_i,
	input wire logic rd_en_i,
	output logic [DATA_W-1:0] rd_data_o
);
	localparam dprc_shape_t SHAPE = dprc_shape_of(ADDR_W);
	localparam int BW = dprc_shape_width(SHAPE);
	localparam int BAW = dprc_shape_aw(SHAPE);
	localparam int NB = dprc_blocks(DATA_W, ADDR_W);
	localparam int PW = NB * BW;

	////////////////////////////////////////////////////////////////////////////////
	// clocking scheme

	dprc_clk_mode_t mode;
	logic clr_n;
	logic in_stb;
	logic out_tick;
	logic rd_stb;
	logic dout_stb;

	assign mode = dprc_clk_mode_t'(clk_mode_i);
	assign clr_n = reset_n_i & ~aclr_i;

	assign in_stb = in_tick_i & in_clken_i;
	// single mode reuses the input tick so one source drives everything
	assign out_tick = (mode == DPRC_MODE_SINGLE) ? in_tick_i : out_tick_i;
	assign dout_stb = out_tick & out_clken_i;

	// read group clock chosen by mode
	always_comb begin
		case (mode)
			DPRC_MODE_SEP_RW: rd_stb = dout_stb;
			DPRC_MODE_SEP_IO: rd_stb = in_stb;
			DPRC_MODE_SINGLE: rd_stb = in_stb;
			default: rd_stb = in_stb;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// input registers

	logic [DATA_W-1:0] din_q, din_d;
	logic [ADDR_W-1:0] waddr_q, waddr_d;
	logic we_q, we_d;
	logic [ADDR_W-1:0] raddr_q, raddr_d;
	logic re_q, re_d;

	always_comb begin
		din_d = din_q;
		waddr_d = waddr_q;
		we_d = we_q;
		if (in_stb) begin
			din_d = wr_data_i;
			waddr_d = wr_addr_i;
			we_d = wr_en_i;
		end
	end

	// read group on its selected tick
	always_comb begin
		raddr_d = raddr_q;
		re_d = re_q;
		if (rd_stb) begin
			raddr_d = rd_addr_i;
			re_d = rd_en_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge clr_n) begin
		if (!clr_n) begin
			din_q <= '0;
			waddr_q <= '0;
			we_q <= 1'b0;
			raddr_q <= '0;
			re_q <= 1'b0;
		end else begin
			din_q <= din_d;
			waddr_q <= waddr_d;
			we_q <= we_d;
			raddr_q <= raddr_d;
			re_q <= re_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered or direct inputs

	logic [DATA_W-1:0] eff_din;
	logic [ADDR_W-1:0] eff_waddr;
	logic eff_we;
	logic [ADDR_W-1:0] eff_raddr;
	logic eff_re;

	assign eff_din = reg_sel_i[DPRC_SEL_DIN] ? din_q : wr_data_i;
	assign eff_waddr = reg_sel_i[DPRC_SEL_WADDR] ? waddr_q : wr_addr_i;
	assign eff_we = reg_sel_i[DPRC_SEL_WE] ? we_q : wr_en_i;
	assign eff_raddr = reg_sel_i[DPRC_SEL_RADDR] ? raddr_q : rd_addr_i;
	assign eff_re = reg_sel_i[DPRC_SEL_RE] ? re_q : rd_en_i;

	////////////////////////////////////////////////////////////////////////////////
	// memory blocks

	logic blk_we;
	logic [PW-1:0] wpad;
	logic [PW-1:0] rpad;
	logic [BAW-1:0] blk_waddr;
	logic [BAW-1:0] blk_raddr;

	// write paced only by the input tick
	assign blk_we = eff_we & in_stb;

	// zero-extend to block widths; spare lanes of the top block stay unused
	always_comb begin
		wpad = '0;
		wpad[DATA_W-1:0] = eff_din;
		blk_waddr = '0;
		blk_waddr[ADDR_W-1:0] = eff_waddr;
		blk_raddr = '0;
		blk_raddr[ADDR_W-1:0] = eff_raddr;
	end

	// one block per slice of the word
	for (genvar b = 0; b < NB; b++) begin : g_blk
		dprc_mem_if #(.AW(BAW), .BW(BW)) blk_if ();

		assign blk_if.we = blk_we;
		assign blk_if.waddr = blk_waddr;
		assign blk_if.wdata = wpad[b*BW +: BW];
		assign blk_if.raddr = blk_raddr;
		assign rpad[b*BW +: BW] = blk_if.rdata;

		// each block fixed at full capacity
		dprc_mem_block #(
			.SHAPE(SHAPE),
			.INIT_IMAGE(INIT_IMAGE[b*DPRC_BLOCK_BITS +: DPRC_BLOCK_BITS])
		) u_blk (
			.clk_sys_i(clk_sys_i),
			.reset_n_i(reset_n_i),
			.port(blk_if.mem)
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// output register

	logic [DATA_W-1:0] dout_q, dout_d;
	logic dout_load;

	// direct output still passes one flop, updated every system clock while read enable is high
	assign dout_load = eff_re & (reg_sel_i[DPRC_SEL_DOUT] ? dout_stb : 1'b1);

	always_comb begin
		dout_d = dout_q;
		if (dout_load) begin
			dout_d = rpad[DATA_W-1:0];
		end
	end

	always_ff @(posedge clk_sys_i or negedge clr_n) begin
		if (!clr_n) begin
			dout_q <= '0;
		end else begin
			dout_q <= dout_d;
		end
	end

	assign rd_data_o = dout_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	a_in_group_hold: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		!in_stb |=> $stable(din_q) && $stable(waddr_q) && $stable(we_q))
		else $error("input register moved without input enable");

	a_out_group_hold: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		(reg_sel_i[DPRC_SEL_DOUT] && !dout_stb) |=> $stable(rd_data_o))
		else $error("output register moved without output enable");

	a_sep_rw_read: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		(mode == DPRC_MODE_SEP_RW) |-> (rd_stb == (out_tick_i & out_clken_i)))
		else $error("read group not on output clock in read/write mode");

	a_sep_io_read: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		(mode == DPRC_MODE_SEP_IO) |-> (rd_stb == in_stb))
		else $error("read group not on input clock in input/output mode");

	a_rd_addr_capture: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		rd_stb |=> raddr_q == $past(rd_addr_i) && re_q == $past(rd_en_i))
		else $error("read address register missed its tick");

	a_wr_on_input: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		blk_we |-> in_stb && eff_we)
		else $error("write issued outside input tick");

	a_write_paced: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		(eff_we && in_stb) |-> blk_we)
		else $error("write lost while output side idle");

	a_read_data: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		dout_load |=> rd_data_o == $past(rpad[DATA_W-1:0]))
		else $error("read data not delivered");

	a_clear_regs: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		$fell(aclr_i) |-> din_q == '0 && waddr_q == '0 && raddr_q == '0 && rd_data_o == '0)
		else $error("clear did not reset the registers");

	a_clear_now: assert property (@(posedge clk_sys_i)
		!clr_n |-> (dout_q == '0 && we_q == 1'b0 && re_q == 1'b0))
		else $error("registers not cleared while clear held");

	a_wr_capture: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		in_stb |=> din_q == $past(wr_data_i) && waddr_q == $past(wr_addr_i)
			&& we_q == $past(wr_en_i))
		else $error("write group missed its input tick");

	a_rd_group_hold: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		!rd_stb |=> $stable(raddr_q) && $stable(re_q))
		else $error("read group moved without its strobe");

	a_io_dout_clock: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		(mode == DPRC_MODE_SEP_IO) |-> (dout_stb == (out_tick_i & out_clken_i)))
		else $error("data out not on output clock in input/output mode");

	a_rw_dout_clock: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		(mode == DPRC_MODE_SEP_RW) |-> (dout_stb == (out_tick_i & out_clken_i)))
		else $error("data out not on output clock in read/write mode");

	a_single_clock: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		(mode == DPRC_MODE_SINGLE) |-> (rd_stb == in_stb
			&& dout_stb == (in_tick_i & out_clken_i)))
		else $error("single clock mode not on the input tick");

	a_idle_read_hold: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		!eff_re |=> $stable(rd_data_o))
		else $error("read data moved without read enable");

	a_direct_out: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		(!reg_sel_i[DPRC_SEL_DOUT] && eff_re) |=> rd_data_o == $past(rpad[DATA_W-1:0]))
		else $error("direct data out did not follow the array");

	a_direct_raddr: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		!reg_sel_i[DPRC_SEL_RADDR] |-> blk_raddr[ADDR_W-1:0] == rd_addr_i)
		else $error("direct read address not applied");

	a_reg_raddr: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		reg_sel_i[DPRC_SEL_RADDR] |-> blk_raddr[ADDR_W-1:0] == raddr_q)
		else $error("registered read address not applied");

	a_write_gated: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		!in_clken_i |-> !blk_we)
		else $error("write issued with input enable low");

	a_out_gated: assert property (@(posedge clk_sys_i) disable iff (!clr_n)
		!out_clken_i |-> !dout_stb)
		else $error("output strobe with output enable low");

endmodule // dprc_ram

/* dprc_user_clk.sv */
// user-side tick maker standing in for the logic that clocks the ram
`timescale 1ns/1ns
module dprc_user_clk (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// tick periods in system cycles, 1 means every cycle
	input wire logic [3:0] in_div_i,
	input wire logic [3:0] out_div_i,
	input wire logic single_i,
	// ticks
	output logic in_tick_o,
	output logic out_tick_o
);
	logic [3:0] in_cnt_q;
	logic [3:0] in_cnt_d;
	logic [3:0] out_cnt_q;
	logic [3:0] out_cnt_d;

	////////////////////////////////////////////////////////////////////////////
	// unrelated tick rates
	always_comb begin
		in_cnt_d = (in_cnt_q + 4'h1 >= in_div_i) ? 4'h0 : in_cnt_q + 4'h1;
		out_cnt_d = (out_cnt_q + 4'h1 >= out_div_i) ? 4'h0 : out_cnt_q + 4'h1;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			in_cnt_q <= 4'h0;
			out_cnt_q <= 4'h0;
		end else begin
			in_cnt_q <= in_cnt_d;
			out_cnt_q <= out_cnt_d;
		end
	end

	assign in_tick_o = (in_cnt_q == 4'h0);
	assign out_tick_o = single_i ? in_tick_o : (out_cnt_q == 4'h0);
endmodule // dprc_user_clk

/* dprc_ram_tb.sv */
// self-checking bench of the dual-port ram clocking block
`timescale 1ns/1ns
module dprc_ram_tb;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b1;
	logic aclr = 1'b0;
	logic in_tick;
	logic out_tick;
	logic in_clken = 1'b1;
	logic out_clken = 1'b1;
	logic [1:0] clk_mode = 2'h0;
	logic [5:0] reg_sel = 6'h00;
	logic [15:0] wr_data = 16'h0000;
	logic [8:0] wr_addr = 9'h000;
	logic wr_en = 1'b0;
	logic [8:0] rd_addr = 9'h000;
	logic rd_en = 1'b0;
	logic [15:0] rd_data;
	logic [3:0] in_div = 4'h1;
	logic [3:0] out_div = 4'h1;
	logic single = 1'b0;
	logic [15:0] shadow [512];
	logic [5:0] sels [4] = '{6'h00, 6'h3F, 6'h15, 6'h2A};
	logic [8:0] a;
	logic [15:0] d;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;

	always #4 clk_sys_i = ~clk_sys_i;

	dprc_ram #(.DATA_W(16), .ADDR_W(9), .INIT_IMAGE({{512{8'h3C}}, {512{8'hA5}}})) dprc_ram_i (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .aclr_i(aclr),
		.in_tick_i(in_tick), .out_tick_i(out_tick),
		.in_clken_i(in_clken), .out_clken_i(out_clken),
		.clk_mode_i(clk_mode), .reg_sel_i(reg_sel),
		.wr_data_i(wr_data), .wr_addr_i(wr_addr), .wr_en_i(wr_en),
		.rd_addr_i(rd_addr), .rd_en_i(rd_en), .rd_data_o(rd_data));

	dprc_user_clk dprc_user_clk_i (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .in_div_i(in_div),
		.out_div_i(out_div), .single_i(single), .in_tick_o(in_tick), .out_tick_o(out_tick));

	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("compares %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// counts edges where the chosen group strobe was sampled high; gives up quietly
	task automatic wait_str(input int n, input bit outs);
		int seen;
		int k;
		seen = 0;
		for (k = 0; k < 40 && seen < n; k++) begin
			@(posedge clk_sys_i);
			if (outs ? (out_tick & out_clken) : (in_tick & in_clken)) begin
				seen++;
			end
		end
	endtask

	// holds both ports long enough for every registering choice, then releases
	task automatic xfer(input bit we, input logic [8:0] wa, input logic [15:0] wd,
		input bit re, input logic [8:0] ra);
		@(posedge clk_sys_i);
		wr_en <= we;
		wr_addr <= wa;
		wr_data <= wd;
		rd_en <= re;
		rd_addr <= ra;
		wait_str(3, 1'b0);
		wait_str(3, 1'b1);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		wait_str(2, 1'b0);
		wait_str(2, 1'b1);
	endtask

	task automatic rd(input logic [8:0] ra, input logic [15:0] exp);
		xfer(1'b0, 9'h000, 16'h0000, 1'b1, ra);
		cmp(rd_data, exp);
	endtask

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		foreach (shadow[i]) shadow[i] = 16'h3CA5;
		// a real falling edge at time zero resets every flop before the first clock
		reset_n_i <= 1'b0;
		repeat (12) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		@(negedge clk_sys_i);
		cmp(rd_data, 16'h0000);
		rd(9'h005, 16'h3CA5);
		rd(9'h1FF, 16'h3CA5);
		for (int m = 0; m < 3; m++) begin
			for (int s = 0; s < 4; s++) begin
				clk_mode <= m[1:0];
				reg_sel <= sels[s];
				single <= (m == 2);
				in_div <= (m == 2) ? 4'h2 : 4'h3;
				out_div <= (m == 2) ? 4'h2 : 4'h5;
				a = 9'h100 + 9'(16 * m + 4 * s);
				d = {m[3:0], s[3:0], 8'hC3};
				// write one place while reading another, never the same one
				xfer(1'b1, a, d, 1'b1, a - 9'h001);
				cmp(rd_data, shadow[a - 9'h001]);
				shadow[a] = d;
				rd(a, d);
			end
		end
		clk_mode <= 2'h1;
		reg_sel <= 6'h3F;
		in_div <= 4'h1;
		out_div <= 4'h1;
		single <= 1'b0;
		rd(9'h050, 16'h3CA5);
		out_clken <= 1'b0;
		xfer(1'b1, 9'h050, 16'h5A5A, 1'b0, 9'h000);
		rd(9'h050, 16'h3CA5);
		out_clken <= 1'b1;
		rd(9'h050, 16'h5A5A);
		in_clken <= 1'b0;
		reg_sel <= 6'h27;
		xfer(1'b1, 9'h060, 16'hBEEF, 1'b0, 9'h000);
		rd(9'h060, 16'h3CA5);
		in_clken <= 1'b1;
		@(posedge clk_sys_i);
		aclr <= 1'b1;
		@(negedge clk_sys_i);
		cmp(rd_data, 16'h0000);
		@(posedge clk_sys_i);
		aclr <= 1'b0;
		rd(9'h050, 16'h5A5A);
		print_verdict();
	end
endmodule // dprc_ram_tb
